// ==== design/dgs_diag_regs.sv ====
// top of the diagnostic, pin direction, chain select and mask registers
`timescale 1ns/1ps
// Behaviour
// - hold-off bit set: closed break switches never force gain to 1/16.
// - writing 1 to bit 3 or bit 2 closes that switch; both allowed.
// - switch closed and hold-off clear: default gain replaces programmed gain.
// - gain register reads keep showing programmed values during override.
// - both switches open again: programmed gain is applied once more.
// - two-bit current select sets both sources: 250n, 2u, 4u default, 16u.
// - direction bit 1 makes pin output, 0 input; reset is all inputs.
// - pin with map bit and output direction becomes downstream chip select.
// - first pulse to lowest enabled pin, then others in order, last self.
// - chain repeats round robin until reconfigured; host counts pulses.
// - analog mask bit 1, except bit 3, disables that flag and its interrupt share.
// - both input channel pairs refused together unless override bit is 1.
// - digital mask bit 1 disables the matching digital flag.
// - checksum disable bit clear: checksum bytes on writes and reads.
// - freeze bit clear: tick counter increments; set: it halts.
// - break-test fault sets during a test and clears on write of 1.
// - fault interrupt is OR of all unmasked analog and digital flags.
module dgs_diag_regs
  import dgs_pkg::*;
#(
  parameter int GAIN_W = 6,
  parameter logic [5:0] GAIN_DEFAULT = 6'h00,
  parameter int TICK_W = 16,
  parameter int TICK_DIV = DGS_TICK_DIV
) (
  input wire logic ref_clk,
  input wire logic rst,
  // register port
  input wire dgs_reg_req_type reg_req,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  output logic reg_addr_err,
  // gain path
  input wire logic [GAIN_W-1:0] programmed_gain,
  output logic [GAIN_W-1:0] applied_gain,
  output logic gain_override_active,
  // wire-break test
  output logic break_switch_pos,
  output logic break_switch_neg,
  output logic [1:0] break_current_sel,
  output logic [15:0] break_current_na,
  input wire logic break_detect,
  // input channel switches
  input wire logic ch1_request,
  input wire logic ch2_request,
  output logic ch1_connect,
  output logic ch2_connect,
  // fault events and interrupt
  input wire logic [7:0] analog_fault_event,
  input wire logic [7:0] digital_fault_event,
  output logic fault_int,
  // bus framing and tick counter
  output logic checksum_enable,
  output logic [TICK_W-1:0] master_tick_counter,
  // general pins
  input wire logic [6:0] general_pin_in,
  input wire logic [6:0] general_pin_data,
  output logic [6:0] general_pin_out,
  output logic [6:0] general_pin_oe_n,
  output logic [6:0] pin_read_value,
  // host chip select
  input wire logic host_cs_n,
  output logic self_cs_n
);

  // ------------------------------------------------------------------
  // register storage
  // ------------------------------------------------------------------
  logic [7:0] wire_break_control;
  logic [7:0] pin_direction_control;
  logic [7:0] chained_select_map;
  logic [7:0] analog_fault_mask;
  logic [7:0] digital_fault_mask;
  logic [7:0] analog_flags;
  logic [7:0] digital_flags;

  // ------------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------------
  wire hit_wb = (reg_req.addr == DGS_OFS_WIRE_BREAK);
  wire hit_dir = (reg_req.addr == DGS_OFS_PIN_DIR);
  wire hit_map = (reg_req.addr == DGS_OFS_CHAIN_MAP);
  wire hit_amask = (reg_req.addr == DGS_OFS_ANALOG_MASK);
  wire hit_dmask = (reg_req.addr == DGS_OFS_DIGITAL_MASK);
  wire hit_aflag = (reg_req.addr == DGS_OFS_ANALOG_FLAGS);
  wire hit_dflag = (reg_req.addr == DGS_OFS_DIGITAL_FLAGS);
  wire hit_any = hit_wb | hit_dir | hit_map | hit_amask | hit_dmask |
                 hit_aflag | hit_dflag;
  wire wr_wb = reg_req.wr && hit_wb;
  wire wr_dir = reg_req.wr && hit_dir;
  wire wr_map = reg_req.wr && hit_map;
  wire wr_amask = reg_req.wr && hit_amask;
  wire wr_dmask = reg_req.wr && hit_dmask;
  wire wr_aflag = reg_req.wr && hit_aflag;
  wire wr_dflag = reg_req.wr && hit_dflag;

  // ------------------------------------------------------------------
  // configuration registers; reserved bits masked off on write
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wire_break_control <= DGS_RST_WIRE_BREAK;
      pin_direction_control <= DGS_RST_PIN_DIR;
      chained_select_map <= DGS_RST_CHAIN_MAP;
      analog_fault_mask <= DGS_RST_ANALOG_MASK;
      digital_fault_mask <= DGS_RST_DIGITAL_MASK;
    end else begin
      if (wr_wb) begin
        wire_break_control <= reg_req.wdata & DGS_WMASK_WIRE_BREAK;
      end
      if (wr_dir) begin
        pin_direction_control <= reg_req.wdata & DGS_WMASK_PINS;
      end
      if (wr_map) begin
        chained_select_map <= reg_req.wdata & DGS_WMASK_PINS;
      end
      if (wr_amask) begin
        analog_fault_mask <= reg_req.wdata & DGS_WMASK_ANALOG;
      end
      if (wr_dmask) begin
        digital_fault_mask <= reg_req.wdata & DGS_WMASK_DIGITAL;
      end
    end
  end

  // ------------------------------------------------------------------
  // wire-break test fields and gain override
  // ------------------------------------------------------------------
  wire hold_off = wire_break_control[DGS_BIT_HOLD_OFF];
  wire sw_closed = wire_break_control[DGS_BIT_SW_POS] |
                   wire_break_control[DGS_BIT_SW_NEG];

  // each switch has its own bit, so both can be closed together
  assign break_switch_pos = wire_break_control[DGS_BIT_SW_POS];
  assign break_switch_neg = wire_break_control[DGS_BIT_SW_NEG];
  assign break_current_sel = wire_break_control[DGS_BIT_CUR_HI:
                                                DGS_BIT_CUR_LO];
  assign break_current_na = dgs_current_na(break_current_sel);

  // override only selects; the programmed gain is never overwritten,
  // so reads stay true and release restores it with no saved copy
  assign gain_override_active = sw_closed && !hold_off;
  assign applied_gain = gain_override_active ? GAIN_DEFAULT
                                             : programmed_gain;

  // ------------------------------------------------------------------
  // input channel exclusion; channel 1 wins a simultaneous request
  // ------------------------------------------------------------------
  wire excl_override = analog_fault_mask[DGS_BIT_EXCL_OVR];
  assign ch1_connect = ch1_request;
  assign ch2_connect = ch2_request &&
                       (!ch1_request || excl_override);

  // ------------------------------------------------------------------
  // fault flags: set wins over a same-cycle write-1 clear
  // ------------------------------------------------------------------
  // bit 3 of the analog mask is the exclusion override, not a mask
  wire [7:0] analog_enable = ~analog_fault_mask & DGS_WMASK_ANALOG &
                             ~(8'h01 << DGS_BIT_FAULT_INT);
  wire [7:0] digital_enable = ~digital_fault_mask & DGS_WMASK_DIGITAL;

  // break fault only counts while a test switch is closed
  wire [7:0] break_event = (break_detect && sw_closed) ?
                           (8'h01 << DGS_BIT_BREAK_FLAG) : 8'h00;
  wire [7:0] analog_src = (analog_fault_event &
                           ~(8'h01 << DGS_BIT_FAULT_INT)) | break_event;
  wire [7:0] analog_set = analog_src & analog_enable;
  wire [7:0] digital_set = digital_fault_event & digital_enable;

  // combined fault: unmasked flags of both groups
  wire fault_any = |(analog_flags & analog_enable) |
                   |(digital_flags & digital_enable);
  wire [7:0] fault_int_set = fault_any ? (8'h01 << DGS_BIT_FAULT_INT)
                                       : 8'h00;

  wire [7:0] analog_clr = wr_aflag ? (reg_req.wdata & DGS_WMASK_ANALOG)
                                   : 8'h00;
  wire [7:0] digital_clr = wr_dflag ? (reg_req.wdata & DGS_WMASK_DIGITAL)
                                    : 8'h00;
  wire [7:0] next_analog_flags = (analog_flags & ~analog_clr) |
                                 analog_set | fault_int_set;
  wire [7:0] next_digital_flags = (digital_flags & ~digital_clr) |
                                  digital_set;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      analog_flags <= DGS_RST_FLAGS;
      digital_flags <= DGS_RST_FLAGS;
    end else begin
      analog_flags <= next_analog_flags;
      digital_flags <= next_digital_flags;
    end
  end

  assign fault_int = fault_any;

  // ------------------------------------------------------------------
  // bus framing mode and master tick counter
  // ------------------------------------------------------------------
  // the framer outside must apply this from the next frame, not mid-frame
  assign checksum_enable = !digital_fault_mask[DGS_BIT_CSUM_DIS];

  dgs_tick_counter #(
    .DIV(TICK_DIV),
    .WIDTH(TICK_W)
  ) u_tick (
    .ref_clk(ref_clk),
    .rst(rst),
    .freeze(digital_fault_mask[DGS_BIT_TICK_FRZ]),
    .count(master_tick_counter)
  );

  // ------------------------------------------------------------------
  // chained chip select
  // ------------------------------------------------------------------
  wire [6:0] pin_is_out = pin_direction_control[6:0];
  wire [6:0] chain_en = chained_select_map[6:0] & pin_is_out;
  // restart a cycle after the write, once the new enables are in place
  logic chain_restart;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      chain_restart <= 1'b0;
    end else begin
      chain_restart <= wr_dir | wr_map;
    end
  end
  wire [6:0] chain_cs_n;

  dgs_chain_select u_chain (
    .ref_clk(ref_clk),
    .rst(rst),
    .chain_en(chain_en),
    .restart(chain_restart),
    .host_cs_n(host_cs_n),
    .pin_cs_n(chain_cs_n),
    .self_cs_n(self_cs_n),
    .slot()
  );

  // ------------------------------------------------------------------
  // general pins: chip-select pins carry the routed select
  // ------------------------------------------------------------------
  // pull-ups on chained pins are the board's job during reconfiguration
  assign general_pin_oe_n = ~pin_is_out;
  assign general_pin_out = (chain_en & chain_cs_n) |
                           (~chain_en & general_pin_data);
  assign pin_read_value = (pin_is_out & general_pin_data) |
                          (~pin_is_out & general_pin_in);

  // ------------------------------------------------------------------
  // read mux; unmapped reads return zero and flag an address error
  // ------------------------------------------------------------------
  wire [7:0] read_mux =
    hit_wb ? wire_break_control :
    hit_dir ? pin_direction_control :
    hit_map ? chained_select_map :
    hit_amask ? analog_fault_mask :
    hit_dmask ? digital_fault_mask :
    hit_aflag ? analog_flags :
    hit_dflag ? digital_flags : 8'h00;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
      reg_addr_err <= 1'b0;
    end else begin
      reg_rvalid <= reg_req.rd;
      reg_addr_err <= (reg_req.rd || reg_req.wr) && !hit_any;
      if (reg_req.rd) begin
        reg_rdata <= read_mux;
      end
    end
  end

endmodule

// ==== design/dgs_pkg.sv ====
// package: register map, field layout, reset values and timing for diag regs
package dgs_pkg;

  // ------------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------------
  localparam logic [7:0] DGS_OFS_DIGITAL_FLAGS = 8'h03;
  localparam logic [7:0] DGS_OFS_ANALOG_FLAGS = 8'h04;
  localparam logic [7:0] DGS_OFS_WIRE_BREAK = 8'h07;
  localparam logic [7:0] DGS_OFS_PIN_DIR = 8'h08;
  localparam logic [7:0] DGS_OFS_CHAIN_MAP = 8'h09;
  localparam logic [7:0] DGS_OFS_ANALOG_MASK = 8'h0A;
  localparam logic [7:0] DGS_OFS_DIGITAL_MASK = 8'h0B;

  // ------------------------------------------------------------------
  // reset values and writable bits (reserved bits stay zero)
  // ------------------------------------------------------------------
  localparam logic [7:0] DGS_RST_WIRE_BREAK = 8'h02;
  localparam logic [7:0] DGS_RST_PIN_DIR = 8'h00;
  localparam logic [7:0] DGS_RST_CHAIN_MAP = 8'h00;
  localparam logic [7:0] DGS_RST_ANALOG_MASK = 8'h00;
  localparam logic [7:0] DGS_RST_DIGITAL_MASK = 8'h20;
  localparam logic [7:0] DGS_RST_FLAGS = 8'h00;
  localparam logic [7:0] DGS_WMASK_WIRE_BREAK = 8'h8F;
  localparam logic [7:0] DGS_WMASK_PINS = 8'h7F;
  localparam logic [7:0] DGS_WMASK_ANALOG = 8'hDF;
  localparam logic [7:0] DGS_WMASK_DIGITAL = 8'h7F;

  // ------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------
  localparam int DGS_BIT_HOLD_OFF = 7;
  localparam int DGS_BIT_SW_POS = 3;
  localparam int DGS_BIT_SW_NEG = 2;
  localparam int DGS_BIT_CUR_HI = 1;
  localparam int DGS_BIT_CUR_LO = 0;
  localparam int DGS_BIT_BREAK_FLAG = 4;
  localparam int DGS_BIT_FAULT_INT = 3;
  localparam int DGS_BIT_EXCL_OVR = 3;
  localparam int DGS_BIT_CSUM_DIS = 5;
  localparam int DGS_BIT_TICK_FRZ = 2;
  localparam int DGS_NUM_PINS = 7;
  localparam logic [2:0] DGS_SLOT_SELF = 3'h7;

  // ------------------------------------------------------------------
  // break-test current values in nA
  // ------------------------------------------------------------------
  localparam logic [15:0] DGS_CUR_250NA = 16'h00FA;
  localparam logic [15:0] DGS_CUR_2UA = 16'h07D0;
  localparam logic [15:0] DGS_CUR_4UA = 16'h0FA0;
  localparam logic [15:0] DGS_CUR_16UA = 16'h3E80;

  // ------------------------------------------------------------------
  // timing: master tick derived from the reference clock
  // ------------------------------------------------------------------
  localparam int DGS_REF_CLK_HZ = 40_000_000;
  localparam int DGS_MASTER_CLK_HZ = 1_000_000;
  localparam int DGS_TICK_DIV = DGS_REF_CLK_HZ / DGS_MASTER_CLK_HZ;

  // register port request carrier
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dgs_reg_req_type;

  // current select decode, shared with any reader of the code
  function automatic logic [15:0] dgs_current_na(input logic [1:0] sel);
    case (sel)
      2'b00: dgs_current_na = DGS_CUR_250NA;
      2'b01: dgs_current_na = DGS_CUR_2UA;
      2'b10: dgs_current_na = DGS_CUR_4UA;
      default: dgs_current_na = DGS_CUR_16UA;
    endcase
  endfunction

endpackage

// ==== design/dgs_tick_counter.sv ====
// master tick counter with divider enable and freeze control
`timescale 1ns/1ps
module dgs_tick_counter
  import dgs_pkg::*;
#(
  parameter int DIV = DGS_TICK_DIV,
  parameter int WIDTH = 16
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic freeze,
  output logic [WIDTH-1:0] count
);

  // ------------------------------------------------------------------
  // divider: one-cycle enable at master clock rate
  // ------------------------------------------------------------------
  logic [7:0] div_cnt;
  wire div_wrap = (div_cnt == 8'(DIV - 1));

  always_ff @(posedge ref_clk) begin
    if (rst || div_wrap) begin
      div_cnt <= 8'h00;
    end else begin
      div_cnt <= div_cnt + 8'h01;
    end
  end

  // ------------------------------------------------------------------
  // counter: divider keeps running so unfreeze resumes on phase
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      count <= '0;
    end else if (div_wrap && !freeze) begin
      count <= count + 1'b1;
    end
  end

endmodule

// ==== design/dgs_chain_select.sv ====
// chained chip-select sequencer: routes host select pulses round robin
`timescale 1ns/1ps
module dgs_chain_select
  import dgs_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [6:0] chain_en,
  input wire logic restart,
  input wire logic host_cs_n,
  output logic [6:0] pin_cs_n,
  output logic self_cs_n,
  output logic [2:0] slot
);

  // next enabled slot after cur; self after the last pin, then wrap
  function automatic logic [2:0] next_slot(input logic [6:0] en,
                                           input logic [2:0] cur);
    logic [2:0] res;
    logic found;
    res = DGS_SLOT_SELF;
    found = 1'b0;
    for (int j = 0; j < DGS_NUM_PINS; j++) begin
      if (!found && en[j] && (cur == DGS_SLOT_SELF || 3'(j) > cur)) begin
        res = 3'(j);
        found = 1'b1;
      end
    end
    next_slot = res;
  endfunction

  logic cs_prev;
  wire cs_end = host_cs_n && !cs_prev;

  // ------------------------------------------------------------------
  // slot pointer advances only at the end of a pulse, never mid-frame
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cs_prev <= 1'b1;
      slot <= DGS_SLOT_SELF;
    end else begin
      cs_prev <= host_cs_n;
      if (restart && host_cs_n) begin
        slot <= next_slot(chain_en, DGS_SLOT_SELF);
      end else if (cs_end) begin
        slot <= next_slot(chain_en, slot);
      end
    end
  end

  // routing of the host select to the addressed target
  always_comb begin
    for (int j = 0; j < DGS_NUM_PINS; j++) begin
      pin_cs_n[j] = (slot == 3'(j)) ? host_cs_n : 1'b1;
    end
    self_cs_n = (slot == DGS_SLOT_SELF) ? host_cs_n : 1'b1;
  end

endmodule

// ==== dv/dgs_diag_regs_chk.sv ====
// checker for the diagnostic, pin and mask register block
`timescale 1ns/1ps
module dgs_diag_regs_chk
  import dgs_pkg::*;
#(
  parameter int GAIN_W = 6,
  parameter logic [5:0] GAIN_DEFAULT = 6'h00,
  parameter int TICK_W = 16
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire dgs_reg_req_type reg_req,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic reg_addr_err,
  input wire logic [GAIN_W-1:0] programmed_gain,
  input wire logic [GAIN_W-1:0] applied_gain,
  input wire logic gain_override_active,
  input wire logic break_switch_pos,
  input wire logic break_switch_neg,
  input wire logic [1:0] break_current_sel,
  input wire logic [15:0] break_current_na,
  input wire logic ch1_connect,
  input wire logic ch2_connect,
  input wire logic checksum_enable,
  input wire logic [TICK_W-1:0] master_tick_counter,
  input wire logic [6:0] general_pin_oe_n,
  input wire logic host_cs_n,
  input wire logic self_cs_n
);
  logic hold;
  logic ovr;
  logic frz;
  wire unm;
  wire [15:0] cur_exp;
  wire wr_wb = reg_req.wr && reg_req.addr == 8'h07;
  // ----------
  // shadow of the control bits that have no port of their own
  // ----------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      hold <= 1'b0;
      ovr <= 1'b0;
      frz <= 1'b0;
    end else begin
      if (wr_wb) hold <= reg_req.wdata[7];
      if (reg_req.wr && reg_req.addr == 8'h0A) ovr <= reg_req.wdata[3];
      if (reg_req.wr && reg_req.addr == 8'h0B) frz <= reg_req.wdata[2];
    end
  end
  // decode of mapped offsets and current table
  assign unm = !(reg_req.addr inside {8'h03, 8'h04, [8'h07:8'h0B]});
  assign cur_exp = (break_current_sel == 2'b00) ? 16'h00FA :
                   (break_current_sel == 2'b01) ? 16'h07D0 :
                   (break_current_sel == 2'b10) ? 16'h0FA0 : 16'h3E80;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  property p_ovr;
    gain_override_active == ((break_switch_pos || break_switch_neg) && !hold);
  endproperty
  a_ovr: assert property (p_ovr) else $error("override state wrong");
  property p_gain;
    applied_gain == (gain_override_active ? GAIN_DEFAULT : programmed_gain);
  endproperty
  a_gain: assert property (p_gain) else $error("applied gain wrong");
  property p_cur;
    break_current_na == cur_exp;
  endproperty
  a_cur: assert property (p_cur) else $error("break current wrong");
  property p_unm;
    reg_req.rd && unm |=> reg_rvalid && reg_addr_err && reg_rdata == 8'h00;
  endproperty
  a_unm: assert property (p_unm) else $error("unmapped read wrong");
  property p_oe;
    reg_req.wr && reg_req.addr == 8'h08
      |=> general_pin_oe_n == ~$past(reg_req.wdata[6:0]);
  endproperty
  a_oe: assert property (p_oe) else $error("pin enable wrong");
  property p_cks;
    reg_req.wr && reg_req.addr == 8'h0B
      |=> checksum_enable == !$past(reg_req.wdata[5]);
  endproperty
  a_cks: assert property (p_cks) else $error("checksum enable wrong");
  property p_self;
    !self_cs_n |-> !host_cs_n;
  endproperty
  a_self: assert property (p_self) else $error("self select w/o host");
  property p_excl;
    !ovr |-> !(ch1_connect && ch2_connect);
  endproperty
  a_excl: assert property (p_excl) else $error("both channels on");
  property p_tick;
    $past(frz) |-> $stable(master_tick_counter);
  endproperty
  a_tick: assert property (p_tick) else $error("tick moved frozen");
  c_ovr: cover property (gain_override_active);
  c_self: cover property (!self_cs_n);
  c_err: cover property (reg_addr_err);
endmodule

// ==== dv/dgs_host_model.sv ====
// host side model: issues chip-select pulses and counts them
`timescale 1ns/1ps
module dgs_host_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic go,
  output logic host_cs_n,
  output logic [7:0] pulse_count
);
  logic [1:0] low_cnt;
  // ----------
  // pulse generator
  // ----------
  // each pulse is low three cycles; the host tracks its own count since
  // the device gives no hint of which target is addressed
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      host_cs_n <= 1'b1;
      low_cnt <= 2'h0;
      pulse_count <= 8'h00;
    end else if (host_cs_n && go) begin
      host_cs_n <= 1'b0;
      low_cnt <= 2'h2;
    end else if (!host_cs_n && low_cnt == 2'h0) begin
      host_cs_n <= 1'b1;
      pulse_count <= pulse_count + 8'h01;
    end else if (!host_cs_n) begin
      low_cnt <= low_cnt - 2'h1;
    end
  end
endmodule

// ==== dv/dgs_diag_regs_bench.sv ====
// self-checking bench for the diagnostic and pin configuration registers
`timescale 1ns/1ps
module dgs_diag_regs_bench
  import dgs_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst, break_detect, ch1_request, ch2_request, go;
  dgs_reg_req_type reg_req;
  logic [7:0] reg_rdata, analog_fault_event, digital_fault_event, pulse_count;
  logic reg_rvalid, reg_addr_err, gain_override_active, fault_int;
  logic [5:0] programmed_gain, applied_gain;
  logic break_switch_pos, break_switch_neg, ch1_connect, ch2_connect;
  logic [1:0] break_current_sel;
  logic [15:0] break_current_na, master_tick_counter, t0;
  logic checksum_enable, host_cs_n, self_cs_n;
  logic [6:0] general_pin_in, general_pin_data, general_pin_out;
  logic [6:0] general_pin_oe_n, pin_read_value, d, m;
  int n_mismatch = 0;
  int samples_checked = 0;
  always #12.5 ref_clk = ~ref_clk;
  dgs_diag_regs #(.GAIN_DEFAULT(6'h00), .TICK_DIV(2)) uut (.*);
  dgs_host_model host (.ref_clk(ref_clk), .rst(rst), .go(go),
    .host_cs_n(host_cs_n), .pulse_count(pulse_count));
  // ----------
  // bus tasks and comparisons
  // ----------
  task automatic cyc();
    @(posedge ref_clk);
    #2;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk({15'h0, got}, {15'h0, exp});
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    cyc();
    reg_req = '0;
    cyc();
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] mk,
                    input logic [7:0] exp);
    reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    cyc();
    chk1(reg_rvalid, 1'b1);
    chk({8'h0, reg_rdata & mk}, {8'h0, exp & mk});
    chk1(reg_addr_err, !(a inside {8'h03, 8'h04, [8'h07:8'h0B]}));
    reg_req = '0;
    cyc();
  endtask
  task automatic ev(input logic [7:0] a, input logic [7:0] dg);
    analog_fault_event = a;
    digital_fault_event = dg;
    cyc();
    analog_fault_event = 8'h00;
    digital_fault_event = 8'h00;
    cyc();
  endtask
  task automatic clr();
    wr(8'h03, 8'hFF);
    wr(8'h04, 8'hFF);
  endtask
  // expected target of pulse k: enabled pins low to high, then self
  function automatic logic [2:0] slot_at(input logic [6:0] en, input int k);
    logic [2:0] lst [$];
    for (int i = 0; i < 7; i++) if (en[i]) lst.push_back(i[2:0]);
    lst.push_back(3'h7);
    return lst[k % lst.size()];
  endfunction
  // map written while the host select is high restarts the sequence
  task automatic chain(input logic [6:0] mp, input logic [6:0] dr);
    logic [2:0] s;
    logic [6:0] sel;
    wr(8'h09, {1'b0, mp});
    wr(8'h08, {1'b0, dr});
    for (int k = 0; k < 16; k++) begin
      go = 1'b1;
      cyc();
      go = 1'b0;
      s = slot_at(mp & dr, k);
      sel = (s == 3'h7) ? 7'h00 : 7'h01 << s;
      chk1(self_cs_n, s != 3'h7);
      chk({9'h0, general_pin_out & mp & dr}, {9'h0, ~sel & mp & dr});
      for (int w = 0; w < 10 && !host_cs_n; w++) cyc();
      cyc();
    end
  endtask
  task automatic conclude();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // watchdog: the sequence needs well under ten thousand cycles
  initial begin
    #250_000;
    n_mismatch++;
    conclude();
  end
  // ----------
  // main sequence
  // ----------
  initial begin
    reg_req = '0;
    rst = 1'b1;
    {break_detect, ch1_request, ch2_request, go} = 4'h0;
    analog_fault_event = 8'h00;
    digital_fault_event = 8'h00;
    general_pin_in = 7'h00;
    general_pin_data = 7'h55;
    void'($urandom(43484));
    programmed_gain = 6'h2A;
    repeat (4) @(posedge ref_clk);
    #2;
    rst = 1'b0;
    rd(8'h07, 8'hFF, 8'h02);
    rd(8'h08, 8'hFF, 8'h00);
    rd(8'h09, 8'hFF, 8'h00);
    rd(8'h0A, 8'hFF, 8'h00);
    rd(8'h0B, 8'hFF, 8'h20);
    rd(8'h20, 8'hFF, 8'h00);
    wr(8'h07, 8'hFF);
    rd(8'h07, 8'hFF, 8'h8F);
    chk({14'h0, break_switch_pos, break_switch_neg}, 16'h3);
    chk1(gain_override_active, 1'b0);
    chk({10'h0, applied_gain}, {10'h0, programmed_gain});
    wr(8'h07, 8'h06);
    programmed_gain = 6'($urandom);
    chk1(gain_override_active, 1'b1);
    chk({10'h0, applied_gain}, 16'h0000);
    wr(8'h07, 8'h02);
    chk({10'h0, applied_gain}, {10'h0, programmed_gain});
    for (int i = 0; i < 4; i++) begin
      wr(8'h07, i[7:0]);
      chk(break_current_na, (i == 0) ? 16'd250 : (i == 1) ? 16'd2000 :
          (i == 2) ? 16'd4000 : 16'd16000);
    end
    wr(8'h07, 8'h08);
    break_detect = 1'b1;
    cyc();
    break_detect = 1'b0;
    wr(8'h07, 8'h02);
    rd(8'h04, 8'h10, 8'h10);
    wr(8'h04, 8'h10);
    rd(8'h04, 8'h10, 8'h00);
    clr();
    chk1(fault_int, 1'b0);
    ev(8'h01, 8'h00);
    chk1(fault_int, 1'b1);
    clr();
    wr(8'h0A, 8'h01);
    ev(8'h01, 8'h00);
    chk1(fault_int, 1'b0);
    rd(8'h04, 8'h01, 8'h00);
    ev(8'h00, 8'h01);
    chk1(fault_int, 1'b1);
    clr();
    wr(8'h0B, 8'h21);
    ev(8'h00, 8'h01);
    chk1(fault_int, 1'b0);
    rd(8'h03, 8'h01, 8'h00);
    {ch1_request, ch2_request} = 2'b11;
    cyc();
    chk({14'h0, ch1_connect, ch2_connect}, 16'h2);
    wr(8'h0A, 8'h08);
    chk({14'h0, ch1_connect, ch2_connect}, 16'h3);
    {ch1_request, ch2_request} = 2'b00;
    wr(8'h0B, 8'h00);
    chk1(checksum_enable, 1'b1);
    rd(8'h0B, 8'hFF, 8'h00);
    t0 = master_tick_counter;
    repeat (10) cyc();
    chk1((master_tick_counter - t0) >= 16'd4, 1'b1);
    wr(8'h0B, 8'h24);
    chk1(checksum_enable, 1'b0);
    cyc();
    t0 = master_tick_counter;
    repeat (10) cyc();
    chk(master_tick_counter, t0);
    for (int i = 0; i < 4; i++) begin
      d = 7'($urandom);
      general_pin_in = 7'($urandom);
      wr(8'h08, {1'b1, d});
      rd(8'h08, 8'hFF, {1'b0, d});
      chk({9'h0, general_pin_oe_n}, {9'h0, ~d});
      chk({9'h0, pin_read_value & ~d}, {9'h0, general_pin_in & ~d});
    end
    chain(7'h05, 7'h05);
    m = 7'($urandom);
    d = 7'($urandom);
    chain(m, d | 7'h11);
    conclude();
  end
endmodule
bind dgs_diag_regs dgs_diag_regs_chk #(.GAIN_W(GAIN_W),
  .GAIN_DEFAULT(GAIN_DEFAULT), .TICK_W(TICK_W)) chk_i (.*);
